// ---- verilog/fpod_pkg.sv ----
// Package: encodings and constants for the fp operand decoder
package fpod_pkg;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int OP_HI      = 31;
  localparam int OP_LO      = 26;
  localparam int FMT_HI     = 25;
  localparam int FMT_LO     = 21;
  localparam int FT_HI      = 20;
  localparam int FT_LO      = 16;
  localparam int FS_HI      = 15;
  localparam int FS_LO      = 11;
  localparam int FD_HI      = 10;
  localparam int FD_LO      = 6;
  localparam int FUNC_HI    = 5;
  localparam int FUNC_LO    = 0;
  localparam int COND_W     = 4;
  localparam int REG_W      = 32;
  localparam int NUM_REGS   = 32;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_COP1       = 6'h11;
  localparam logic [5:0] OP_WORD_LOAD  = 6'h39;  // 57
  localparam logic [5:0] OP_WORD_STORE = 6'h31;  // 49

  // Sub-opcodes in the format position
  localparam logic [4:0] SUB_MOVE_FROM = 5'h00;
  localparam logic [4:0] SUB_COPY_FROM = 5'h02;
  localparam logic [4:0] SUB_MOVE_TO   = 5'h04;
  localparam logic [4:0] SUB_COPY_TO   = 5'h06;
  localparam logic [4:0] SUB_BRANCH    = 5'h08;

  // Format field values
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam logic [4:0] FMT_WORD   = 5'h14;
  localparam logic [2:0] SHORT_FORMAT_FIELD_SINGLE = 3'h0;
  localparam logic [2:0] SHORT_FORMAT_FIELD_DOUBLE = 3'h1;
  localparam logic [2:0] SHORT_FORMAT_FIELD_WORD   = 3'h4;

  // Function codes
  localparam logic [5:0] FN_ADD   = 6'h00;
  localparam logic [5:0] FN_SUB   = 6'h01;
  localparam logic [5:0] FN_MUL   = 6'h02;
  localparam logic [5:0] FN_DIV   = 6'h03;
  localparam logic [5:0] FN_ABS   = 6'h05;
  localparam logic [5:0] FN_MOV   = 6'h06;
  localparam logic [5:0] FN_NEG   = 6'h07;
  localparam logic [5:0] FN_CVT_S = 6'h20;
  localparam logic [5:0] FN_CVT_D = 6'h21;
  localparam logic [5:0] FN_CVT_W = 6'h24;
  localparam logic [1:0] FN_CMP_TOP = 2'h3;

  // Condition code bits
  localparam int CC_UN  = 0;
  localparam int CC_EQ  = 1;
  localparam int CC_LT  = 2;
  localparam int CC_SIG = 3;

  typedef enum logic [1:0] {
    FPOD_FMT_S,
    FPOD_FMT_D,
    FPOD_FMT_W,
    FPOD_FMT_NONE
  } fpod_fmt_t;

  typedef enum logic [3:0] {
    FPOD_CLS_NONE,
    FPOD_CLS_LOAD,
    FPOD_CLS_STORE,
    FPOD_CLS_MOVE_TO,
    FPOD_CLS_MOVE_FROM,
    FPOD_CLS_CTL_TO,
    FPOD_CLS_CTL_FROM,
    FPOD_CLS_BRANCH,
    FPOD_CLS_ARITH,
    FPOD_CLS_CONVERT,
    FPOD_CLS_COMPARE
  } fpod_cls_t;

endpackage : fpod_pkg

// ---- verilog/fpod_regs_if.sv ----
// Interface: register file access carrier for the fp operand decoder
`timescale 1ns/10ps
interface fpod_regs_if;
  import fpod_pkg::*;
  logic              wr_en;
  logic [4:0]        wr_addr;
  logic [REG_W-1:0]  wr_data;
  logic [4:0]        rd_addr_a;
  logic [4:0]        rd_addr_b;
  logic [REG_W-1:0]  rd_data_a;
  logic [REG_W-1:0]  rd_data_b;

  modport master (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
                  input rd_data_a, rd_data_b);
  modport slave  (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
                  output rd_data_a, rd_data_b);
endinterface : fpod_regs_if

// ---- verilog/fpod_regfile.sv ----
// Register file: 32 general registers of 32 bits, registered reads
`timescale 1ns/10ps
module fpod_regfile
  import fpod_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  fpod_regs_if.slave bus
);

  logic [REG_W-1:0] mem_q [NUM_REGS];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.rd_data_a <= '0;
      bus.rd_data_b <= '0;
    end else begin
      bus.rd_data_a <= mem_q[bus.rd_addr_a];
      bus.rd_data_b <= mem_q[bus.rd_addr_b];
    end
  end

endmodule : fpod_regfile

// ---- verilog/fpod_decode.sv ----
// Top: fp coprocessor instruction decode and operand handling
//
// Overview of operation
// - Coprocessor disabled: every fp instruction raises coprocessor-unusable, nothing runs.
// - Loads, stores, moves copy bits unchanged, no conversion, no fp exception.
// - Control registers reached only by copy-to/copy-from with integer register.
// - Opcode 57 is word load into register named by target field.
// - Opcode 49 is word store from register named by target field.
// - Arithmetic results are IEEE 754 correctly rounded; done by downstream unit.
// - Format decode: 16/0 single, 17/1 double, 20/4 word.
// - All other format values are reserved and never supported.
// - Each operation accepts only its permitted formats, e.g. abs single/double.
// - Compare code bit0 unordered, bit1 equal, bit2 less-than; never greater.
// - Codes 8-15 signal invalid when unordered; codes 0-7 never do.
// - Compare sets one condition flag; branches test it true or false.
// - Register specifiers select among 32 general registers.
// - Two-register operands use even register plus next odd; specifier names even.
// - Low 32 bits in lower register, high 32 bits in higher register.
// - Single and word operands live in the low word of the pair.
// - Word load, store and move accept any register number.
// - Each general register is 32 bits wide.
// - Conversions fixed-to-float, float-to-fixed, float-to-float with rounding.
// - Odd specifier for double is undefined; single write leaves upper undefined.
`timescale 1ns/10ps
module fpod_decode
  import fpod_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              issue_valid,
  input  wire logic [31:0]       issue_instr,
  input  wire logic              cop_enable,
  input  wire logic [REG_W-1:0]  int_data,
  input  wire logic [REG_W-1:0]  mem_load_data,
  input  wire logic              cmp_unordered,
  input  wire logic              cmp_equal,
  input  wire logic              cmp_less,
  input  wire logic              result_valid,
  input  wire logic [4:0]        result_reg,
  input  wire logic              result_double,
  input  wire logic [63:0]       result_data,
  output logic                   unusable_exc_q,
  output logic                   unimpl_exc_q,
  output logic                   invalid_exc_q,
  output logic                   undefined_q,
  output logic                   cls_valid_q,
  output fpod_cls_t              cls_q,
  output fpod_fmt_t              fmt_q,
  output logic [5:0]             func_q,
  output logic [4:0]             src_reg_q,
  output logic [4:0]             tgt_reg_q,
  output logic [63:0]            src_operand_q,
  output logic [63:0]            alt_operand_q,
  output logic [REG_W-1:0]       store_data_q,
  output logic [REG_W-1:0]       to_int_data_q,
  output logic                   fp_condition_flag_q,
  output logic                   branch_taken_q
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic fpod_fmt_t fmt_decode(input logic [4:0] f);
    case (f)
      FMT_SINGLE: fmt_decode = FPOD_FMT_S;
      FMT_DOUBLE: fmt_decode = FPOD_FMT_D;
      FMT_WORD:   fmt_decode = FPOD_FMT_W;
      default:    fmt_decode = FPOD_FMT_NONE;
    endcase
  endfunction : fmt_decode

  function automatic fpod_fmt_t short_format_field_decode(input logic [2:0] f);
    case (f)
      SHORT_FORMAT_FIELD_SINGLE: short_format_field_decode = FPOD_FMT_S;
      SHORT_FORMAT_FIELD_DOUBLE: short_format_field_decode = FPOD_FMT_D;
      SHORT_FORMAT_FIELD_WORD:   short_format_field_decode = FPOD_FMT_W;
      default:     short_format_field_decode = FPOD_FMT_NONE;
    endcase
  endfunction : short_format_field_decode

  // Pair high: the odd register of the even/odd pair holding r, whatever the format
  function automatic logic [4:0] pair_hi(input logic [4:0] r);
    pair_hi = {r[4:1], 1'b1};
  endfunction : pair_hi

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [5:0]  op;
  logic [4:0]  fmt_f;
  logic [4:0]  ft_f;
  logic [4:0]  fs_f;
  logic [4:0]  fd_f;
  logic [5:0]  fn_f;
  fpod_fmt_t   fmt_d;
  fpod_cls_t   cls_d;
  logic        fmt_ok;
  logic        is_fp;

  assign op    = issue_instr[OP_HI:OP_LO];
  assign fmt_f = issue_instr[FMT_HI:FMT_LO];
  assign ft_f  = issue_instr[FT_HI:FT_LO];
  assign fs_f  = issue_instr[FS_HI:FS_LO];
  assign fd_f  = issue_instr[FD_HI:FD_LO];
  assign fn_f  = issue_instr[FUNC_HI:FUNC_LO];

  // Move-conditional forms carry a short format field in the ft slot
  always_comb begin
    fmt_d = fmt_decode(fmt_f);
    if (op == OP_COP1 && fn_f == 6'h11) begin
      fmt_d = short_format_field_decode(ft_f[4:2]);
    end
  end

  assign is_fp = (op == OP_COP1) || (op == OP_WORD_LOAD) || (op == OP_WORD_STORE);

  // ----------------------------------------------------------------
  // Classification and per-operation format check
  // ----------------------------------------------------------------
  always_comb begin
    cls_d  = FPOD_CLS_NONE;
    fmt_ok = 1'b1;
    if (op == OP_WORD_LOAD) begin
      cls_d = FPOD_CLS_LOAD;
    end else if (op == OP_WORD_STORE) begin
      cls_d = FPOD_CLS_STORE;
    end else if (op == OP_COP1) begin
      case (fmt_f)
        SUB_MOVE_FROM: cls_d = FPOD_CLS_MOVE_FROM;
        SUB_MOVE_TO:   cls_d = FPOD_CLS_MOVE_TO;
        SUB_COPY_FROM: cls_d = FPOD_CLS_CTL_FROM;
        SUB_COPY_TO:   cls_d = FPOD_CLS_CTL_TO;
        SUB_BRANCH:    cls_d = FPOD_CLS_BRANCH;
        default: begin
          if (fn_f[5:4] == FN_CMP_TOP) begin
            cls_d  = FPOD_CLS_COMPARE;
            fmt_ok = (fmt_d == FPOD_FMT_S) || (fmt_d == FPOD_FMT_D);
          end else begin
            case (fn_f)
              FN_ADD, FN_SUB, FN_MUL, FN_DIV, FN_ABS, FN_MOV, FN_NEG: begin
                cls_d  = FPOD_CLS_ARITH;
                fmt_ok = (fmt_d == FPOD_FMT_S) || (fmt_d == FPOD_FMT_D);
              end
              FN_CVT_S: begin
                cls_d  = FPOD_CLS_CONVERT;
                fmt_ok = (fmt_d == FPOD_FMT_D) || (fmt_d == FPOD_FMT_W);
              end
              FN_CVT_D: begin
                cls_d  = FPOD_CLS_CONVERT;
                fmt_ok = (fmt_d == FPOD_FMT_S) || (fmt_d == FPOD_FMT_W);
              end
              FN_CVT_W: begin
                cls_d  = FPOD_CLS_CONVERT;
                fmt_ok = (fmt_d == FPOD_FMT_S) || (fmt_d == FPOD_FMT_D);
              end
              default: begin
                cls_d  = FPOD_CLS_ARITH;
                fmt_ok = 1'b0;
              end
            endcase
          end
          if (fmt_d == FPOD_FMT_NONE) begin
            fmt_ok = 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  fpod_regs_if rf ();

  fpod_regfile u_regfile (
    .clk   (clk),
    .reset (reset),
    .bus   (rf)
  );

  logic       accept;
  logic       formatted;
  logic       odd_double;
  logic       xfer_wr;
  logic [4:0] rd_a_base;
  logic        hi_pend_q;
  logic [4:0]  hi_reg_q;
  logic [31:0] hi_data_q;

  assign accept    = issue_valid && is_fp && cop_enable;
  assign formatted = (cls_d == FPOD_CLS_ARITH) || (cls_d == FPOD_CLS_CONVERT) ||
                     (cls_d == FPOD_CLS_COMPARE);
  assign odd_double = formatted && (fmt_d == FPOD_FMT_D) &&
                      (fs_f[0] || fd_f[0] || ft_f[0]);
  assign xfer_wr   = accept && ((cls_d == FPOD_CLS_LOAD) || (cls_d == FPOD_CLS_MOVE_TO));

  // Store reads the ft slot; word transfers take any register number
  assign rd_a_base = (cls_d == FPOD_CLS_STORE) ? ft_f : fs_f;

  // Read even then odd of a pair on the two ports; the odd read is the high word
  assign rf.rd_addr_a = (formatted && fmt_d == FPOD_FMT_D) ? {rd_a_base[4:1], 1'b0} : rd_a_base;
  assign rf.rd_addr_b = pair_hi(rd_a_base);

  // Word transfers write one register with data copied bit for bit
  always_comb begin
    rf.wr_en   = 1'b0;
    rf.wr_addr = ft_f;
    rf.wr_data = '0;
    if (xfer_wr) begin
      rf.wr_en   = 1'b1;
      rf.wr_addr = (cls_d == FPOD_CLS_LOAD) ? ft_f : fs_f;
      rf.wr_data = (cls_d == FPOD_CLS_LOAD) ? mem_load_data : int_data;
    end else if (result_valid) begin
      rf.wr_en   = 1'b1;
      rf.wr_addr = result_reg;
      rf.wr_data = result_data[31:0];
    end else if (hi_pend_q) begin
      rf.wr_en   = 1'b1;
      rf.wr_addr = hi_reg_q;
      rf.wr_data = hi_data_q;
    end
  end

  // High half of a double result goes to the odd partner next cycle, unless a word transfer or another result takes the write port

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_pend_q <= 1'b0;
      hi_reg_q  <= 5'h00;
      hi_data_q <= 32'h0000_0000;
    end else begin
      hi_pend_q <= result_valid && result_double && !xfer_wr;
      hi_reg_q  <= pair_hi(result_reg);
      hi_data_q <= result_data[63:32];
    end
  end

  // ----------------------------------------------------------------
  // Issue stage outputs
  // ----------------------------------------------------------------
  logic       rd_pend_q;
  fpod_fmt_t  rd_fmt_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      unusable_exc_q <= 1'b0;
      unimpl_exc_q   <= 1'b0;
      undefined_q    <= 1'b0;
      cls_valid_q    <= 1'b0;
      cls_q          <= FPOD_CLS_NONE;
      fmt_q          <= FPOD_FMT_NONE;
      func_q         <= 6'h00;
      src_reg_q      <= 5'h00;
      tgt_reg_q      <= 5'h00;
      rd_pend_q      <= 1'b0;
      rd_fmt_q       <= FPOD_FMT_NONE;
    end else begin
      unusable_exc_q <= issue_valid && is_fp && !cop_enable;
      unimpl_exc_q   <= accept && !fmt_ok;
      undefined_q    <= accept && odd_double;
      cls_valid_q    <= accept && fmt_ok;
      cls_q          <= cls_d;
      fmt_q          <= fmt_d;
      func_q         <= fn_f;
      src_reg_q      <= rd_a_base;
      tgt_reg_q      <= (cls_d == FPOD_CLS_LOAD) ? ft_f : fd_f;
      rd_pend_q      <= accept && fmt_ok;
      rd_fmt_q       <= fmt_d;
    end
  end

  // Operand assembly from registered reads: low word from the even register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_operand_q <= 64'h0;
      alt_operand_q <= 64'h0;
      store_data_q  <= 32'h0000_0000;
      to_int_data_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      if (rd_fmt_q == FPOD_FMT_D) begin
        src_operand_q <= {rf.rd_data_b, rf.rd_data_a};
      end else begin
        src_operand_q <= {32'h0000_0000, rf.rd_data_a};
      end
      alt_operand_q <= {rf.rd_data_b, rf.rd_data_a};
      store_data_q  <= rf.rd_data_a;
      to_int_data_q <= rf.rd_data_a;
    end
  end

  // ----------------------------------------------------------------
  // Compare and condition flag
  // ----------------------------------------------------------------
  logic [COND_W-1:0] cmp_code_q;
  logic              cmp_pend_q;
  logic              pred;

  // Greater-than has no select bit, so it is never part of the predicate
  assign pred = (cmp_code_q[CC_UN] && cmp_unordered) ||
                (cmp_code_q[CC_EQ] && cmp_equal) ||
                (cmp_code_q[CC_LT] && cmp_less);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_code_q <= 4'h0;
      cmp_pend_q <= 1'b0;
    end else begin
      cmp_pend_q <= accept && fmt_ok && (cls_d == FPOD_CLS_COMPARE);
      cmp_code_q <= fn_f[COND_W-1:0];
    end
  end

  // Flag is not interlocked: a branch right behind a compare sees the old value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fp_condition_flag_q <= 1'b0;
      invalid_exc_q       <= 1'b0;
    end else begin
      invalid_exc_q <= cmp_pend_q && cmp_code_q[CC_SIG] && cmp_unordered;
      if (cmp_pend_q) begin
        fp_condition_flag_q <= pred;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      branch_taken_q <= 1'b0;
    end else begin
      // ft bit 0 picks branch-on-true, else branch-on-false
      branch_taken_q <= accept && (cls_d == FPOD_CLS_BRANCH) &&
                        (fp_condition_flag_q == ft_f[0]);
    end
  end

endmodule : fpod_decode

// ---- sim/fpod_decode_checker.sv ----
// Checker: port-level assertions for the fp operand decoder
`timescale 1ns/10ps
module fpod_decode_checker
  import fpod_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic        cop_enable,
  input wire logic        unusable_exc_q,
  input wire logic        unimpl_exc_q,
  input wire logic        invalid_exc_q,
  input wire logic        cls_valid_q,
  input wire fpod_cls_t   cls_q,
  input wire logic        fp_condition_flag_q
);
  logic [5:0] op;
  logic [4:0] fm;
  logic [5:0] fn;
  logic       en;
  logic       cmp;
  assign op  = issue_instr[31:26];
  assign fm  = issue_instr[25:21];
  assign fn  = issue_instr[5:0];
  assign en  = issue_valid && cop_enable;
  assign cmp = en && op == OP_COP1 && fm[4] && fn[5:4] == FN_CMP_TOP;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  unusable_raise_a: assert property (issue_valid && !cop_enable && (op == OP_COP1 ||
    op == OP_WORD_LOAD || op == OP_WORD_STORE) |=> unusable_exc_q && !cls_valid_q)
    else $error("refused instruction not flagged unusable");
  enabled_quiet_a: assert property (en |=> !unusable_exc_q)
    else $error("unusable raised while enabled");
  idle_quiet_a: assert property (!issue_valid |=> !(cls_valid_q || unimpl_exc_q || unusable_exc_q))
    else $error("decode pulse without an issue");
  word_load_a: assert property (en && op == OP_WORD_LOAD |=> cls_valid_q && cls_q == FPOD_CLS_LOAD)
    else $error("word load not classified");
  word_store_a: assert property (en && op == OP_WORD_STORE |=> cls_valid_q && cls_q == FPOD_CLS_STORE)
    else $error("word store not classified");
  move_noexc_a: assert property (en && op == OP_COP1 && (fm == SUB_MOVE_TO || fm == SUB_MOVE_FROM)
    |=> !unimpl_exc_q ##1 !invalid_exc_q) else $error("move raised an fp exception");
  ctl_copy_a: assert property (en && op == OP_COP1 && fm == SUB_COPY_TO |=> cls_q == FPOD_CLS_CTL_TO)
    else $error("control copy not classified");
  reserved_fmt_a: assert property (en && op == OP_COP1 && fm[4] && fm != FMT_SINGLE &&
    fm != FMT_DOUBLE && fm != FMT_WORD && fn == FN_ADD |=> unimpl_exc_q && !cls_valid_q)
    else $error("reserved format accepted");
  quiet_compare_a: assert property (cmp && !fn[3] |-> ##2 !invalid_exc_q)
    else $error("quiet compare signalled invalid");
  flag_hold_a: assert property ($changed(fp_condition_flag_q) |-> $past(cmp, 2))
    else $error("condition flag moved without a compare");
endmodule : fpod_decode_checker

bind fpod_decode fpod_decode_checker u_fpod_decode_checker (.clk(clk), .reset(reset),
  .issue_valid(issue_valid), .issue_instr(issue_instr), .cop_enable(cop_enable),
  .unusable_exc_q(unusable_exc_q), .unimpl_exc_q(unimpl_exc_q), .invalid_exc_q(invalid_exc_q),
  .cls_valid_q(cls_valid_q), .cls_q(cls_q), .fp_condition_flag_q(fp_condition_flag_q));

// ---- sim/fpod_core_model.sv ----
// Partner: arithmetic side answering compares with a chosen relation
`timescale 1ns/10ps
module fpod_core_model
  import fpod_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [2:0]  rel,
  output logic             cmp_unordered,
  output logic             cmp_equal,
  output logic             cmp_less
);
  logic [2:0] rel_q = 3'h5;
  // Relation only valid the cycle after a compare; otherwise it churns
  always @(posedge clk) begin
    if (issue_valid && issue_instr[31:26] == OP_COP1 && issue_instr[25]
        && issue_instr[5:4] == FN_CMP_TOP) begin
      rel_q <= rel;
    end else begin
      rel_q <= ~rel_q;
    end
  end
  assign {cmp_less, cmp_equal, cmp_unordered} = rel_q;
endmodule : fpod_core_model

// ---- sim/fpod_decode_bench.sv ----
// Bench: self-checking testbench for the fp operand decoder
`timescale 1ns/10ps
module fpod_decode_bench
  import fpod_pkg::*;
;
  typedef struct {
    logic unus, unimpl, clsv, undef, brt, chkf, lax;
    fpod_cls_t cls;
    fpod_fmt_t fmt;
    logic [2:0] dk;
    logic [63:0] dv;
    logic [31:0] ins;
  } fpod_note_t;
  logic clk, reset, issue_valid, cop_enable, cu, ce, cl;
  logic [31:0] issue_instr, int_data, mem_load_data;
  logic [2:0] rel;
  logic unusable_exc_q, unimpl_exc_q, invalid_exc_q, undefined_q, cls_valid_q;
  logic fp_condition_flag_q, branch_taken_q;
  fpod_cls_t cls_q;
  fpod_fmt_t fmt_q;
  logic [5:0] func_q;
  logic [4:0] src_reg_q, tgt_reg_q, r;
  logic [63:0] src_operand_q, alt_operand_q;
  logic [31:0] store_data_q, to_int_data_q, d, hi;
  logic [3:0] c;
  logic fl, iv, sen, pend;
  fpod_note_t notes[$];
  fpod_note_t n, m, p;
  int num_errors, comparisons, cyc;

  fpod_decode u_fpod_decode (.clk(clk), .reset(reset), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .cop_enable(cop_enable), .int_data(int_data),
    .mem_load_data(mem_load_data), .cmp_unordered(cu), .cmp_equal(ce), .cmp_less(cl),
    .result_valid(1'b0), .result_reg(5'h00), .result_double(1'b0), .result_data(64'h0),
    .unusable_exc_q(unusable_exc_q), .unimpl_exc_q(unimpl_exc_q),
    .invalid_exc_q(invalid_exc_q), .undefined_q(undefined_q), .cls_valid_q(cls_valid_q),
    .cls_q(cls_q), .fmt_q(fmt_q), .func_q(func_q), .src_reg_q(src_reg_q),
    .tgt_reg_q(tgt_reg_q), .src_operand_q(src_operand_q), .alt_operand_q(alt_operand_q),
    .store_data_q(store_data_q), .to_int_data_q(to_int_data_q),
    .fp_condition_flag_q(fp_condition_flag_q), .branch_taken_q(branch_taken_q));
  fpod_core_model u_fpod_core_model (.clk(clk), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .rel(rel), .cmp_unordered(cu), .cmp_equal(ce), .cmp_less(cl));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  function automatic fpod_note_t nt(logic v, fpod_cls_t k, fpod_fmt_t f, logic [2:0] dk,
                                    logic [63:0] dv);
    fpod_note_t x = '{cls: k, fmt: f, default: '0};
    x.clsv = v; x.chkf = v; x.dk = dk; x.dv = dv;
    return x;
  endfunction : nt

  function automatic logic [31:0] cp(logic [4:0] f, logic [4:0] t, logic [4:0] s,
                                     logic [4:0] dd, logic [5:0] fn);
    return {OP_COP1, f, t, s, dd, fn};
  endfunction : cp

  // Gap 0 keeps valid up for back-to-back issue
  task automatic issue(input logic [31:0] ins, input fpod_note_t x, input int gap);
    x.ins = ins;
    notes.push_back(x);
    issue_valid = 1'b1;
    issue_instr = ins;
    @(posedge clk) #1;
    if (gap > 0) issue_valid = 1'b0;
    repeat (gap) @(posedge clk);
    if (gap > 0) #1;
  endtask : issue

  task automatic ld(input logic [4:0] rr, input logic [31:0] dd, input int gap);
    mem_load_data = dd;
    issue({OP_WORD_LOAD, 5'h01, rr, 16'h0000}, nt(1, FPOD_CLS_LOAD, FPOD_FMT_NONE, 0, 0), gap);
  endtask : ld

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    #2;
    if (pend) begin
      pend = 1'b0;
      if (p.dk == 1) chk({32'h0, store_data_q}, p.dv, "store data");
      if (p.dk == 2) chk({32'h0, to_int_data_q}, p.dv, "move data");
      if (p.dk == 3) chk({invalid_exc_q, fp_condition_flag_q}, p.dv, "compare");
      if (p.dk == 4) chk(src_operand_q, p.dv, "operand");
      if (p.dk == 4) chk(alt_operand_q, {hi, d}, "pair");
    end
    if ((unusable_exc_q | unimpl_exc_q | cls_valid_q | undefined_q) === 1'b1) begin
      if (notes.size() == 0) chk(1, 0, "result with no issue");
      else begin
        m = notes.pop_front();
        if (m.lax) chk(undefined_q, 1, "odd double");
        else begin
          chk(unusable_exc_q, m.unus, "unusable");
          chk(unimpl_exc_q, m.unimpl, "unimplemented");
          chk({cls_valid_q, undefined_q}, {m.clsv, 1'b0}, "accept");
          chk(branch_taken_q, m.brt, "branch");
          if (m.chkf) chk({cls_q, fmt_q}, {m.cls, m.fmt}, "class");
          if (m.chkf) chk({func_q, src_reg_q, tgt_reg_q}, {m.ins[5:0],
            m.ins[(m.cls == FPOD_CLS_STORE ? 16 : 11) +: 5],
            m.ins[(m.cls == FPOD_CLS_LOAD ? 16 : 6) +: 5]}, "fields");
        end
        if (m.dk != 0) begin
          p = m;
          pend = 1'b1;
        end
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1; issue_valid = 1'b0; issue_instr = 32'h0; cop_enable = 1'b1;
    int_data = 32'h0; mem_load_data = 32'h0; rel = 3'h0; pend = 1'b0;
    d = $urandom(6);
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    cop_enable = 1'b0;
    n = nt(0, FPOD_CLS_NONE, FPOD_FMT_NONE, 0, 0);
    n.unus = 1'b1;
    issue(cp(FMT_SINGLE, 4, 2, 6, FN_ADD), n, 2);
    issue({OP_WORD_LOAD, 5'h00, 5'h03, 16'h0000}, n, 2);
    cop_enable = 1'b1;
    $display("test disabled done");
    for (int i = 0; i < 8; i++) begin
      r = 5'($urandom % 32);
      d = $urandom;
      ld(r, d, 2);
      issue({OP_WORD_STORE, 5'h01, r, 16'h0004}, nt(1, FPOD_CLS_STORE, FPOD_FMT_NONE, 1, {32'h0, d}), 2);
    end
    for (int i = 0; i < 4; i++) begin
      r = 5'($urandom % 32);
      int_data = $urandom;
      issue(cp(SUB_MOVE_TO, 8, r, 0, 0), nt(1, FPOD_CLS_MOVE_TO, FPOD_FMT_NONE, 0, 0), 2);
      issue(cp(SUB_MOVE_FROM, 8, r, 0, 0), nt(1, FPOD_CLS_MOVE_FROM, FPOD_FMT_NONE, 2,
            {32'h0, int_data}), 2);
    end
    issue(cp(SUB_COPY_TO, 8, 31, 0, 0), nt(1, FPOD_CLS_CTL_TO, FPOD_FMT_NONE, 0, 0), 2);
    issue(cp(SUB_COPY_FROM, 8, 31, 0, 0), nt(1, FPOD_CLS_CTL_FROM, FPOD_FMT_NONE, 0, 0), 2);
    $display("test transfers done");
    for (int f = 16; f < 32; f++) begin
      if (f == 20) continue;
      n = nt(f < 18, FPOD_CLS_ARITH, f == 16 ? FPOD_FMT_S : FPOD_FMT_D, 0, 0);
      n.unimpl = (f >= 18);
      issue(cp(5'(f), 4, 2, 6, FN_ADD), n, 2);
    end
    issue(cp(FMT_WORD, 0, 2, 4, FN_CVT_S), nt(1, FPOD_CLS_CONVERT, FPOD_FMT_W, 0, 0), 2);
    issue(cp(FMT_SINGLE, 0, 2, 4, FN_CVT_D), nt(1, FPOD_CLS_CONVERT, FPOD_FMT_S, 0, 0), 2);
    issue(cp(FMT_DOUBLE, 0, 2, 4, FN_CVT_W), nt(1, FPOD_CLS_CONVERT, FPOD_FMT_D, 0, 0), 2);
    n = nt(0, FPOD_CLS_NONE, FPOD_FMT_NONE, 0, 0);
    n.unimpl = 1'b1;
    issue(cp(FMT_WORD, 0, 2, 4, FN_ABS), n, 2);
    $display("test formats done");
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      r = 5'($urandom % 4);
      rel = (r == 0) ? 3'h0 : 3'(1 << (r - 1));
      fl = |(c[2:0] & rel);
      iv = c[3] & rel[0];
      issue(cp(FMT_SINGLE, 4, 2, 0, {FN_CMP_TOP, c}), nt(1, FPOD_CLS_COMPARE, FPOD_FMT_S, 3,
            {62'h0, iv, fl}), 2);
      sen = 1'($urandom % 2);
      n = nt(1, FPOD_CLS_BRANCH, FPOD_FMT_NONE, 0, 0);
      n.brt = sen ? fl : !fl;
      issue(cp(SUB_BRANCH, {4'h0, sen}, 0, 0, 0), n, 2);
    end
    $display("test compares done");
    r = 5'(($urandom % 16) * 2);
    d = $urandom;
    hi = $urandom;
    ld(r, d, 0);
    ld(r + 5'h01, hi, 2);
    issue(cp(FMT_DOUBLE, 0, r, 0, FN_ABS), nt(1, FPOD_CLS_ARITH, FPOD_FMT_D, 4, {hi, d}), 2);
    issue(cp(FMT_SINGLE, 0, r, 0, FN_ABS), nt(1, FPOD_CLS_ARITH, FPOD_FMT_S, 4, {32'h0, d}), 2);
    n = nt(0, FPOD_CLS_NONE, FPOD_FMT_NONE, 0, 0);
    n.lax = 1'b1;
    issue(cp(FMT_DOUBLE, 0, r + 5'h01, 0, FN_ABS), n, 2);
    $display("test pairs done");
    repeat (5) @(posedge clk);
    if (notes.size() != 0) chk(notes.size(), 0, "results missing");
    give_verdict();
  end
endmodule : fpod_decode_bench
